// ---- scc_ctrl.sv ----
// What this block does
// - line loopback bit routes received serial line straight to transmit serial line
// - diagnostic loopback bit feeds transmit stream back into receive path
// - loop timing off: transmit clock from transmit reference, per select, bypass, rate
// - loop timing on: receive reference, or recovered clock when recovery active
// - transmit lock-loss state shows synthesizer out of 2930 ppm of reference
// - transmit lock-loss interrupt enable makes each state change pull interrupt low
// - transmit reference select ignored in transmit bypass mode
// - transmit select 0: 19.44 MHz reference, multiply by 8 or 8/3
// - transmit select 1: 6.48 MHz reference, multiply by 24 or 8
// - receive lock-loss state: recovered clock off 2930 ppm, or no transitions 80 bits
// - receive lock-loss interrupt enable makes each state change pull interrupt low
// - receive reference select ignored in receive bypass mode
// - receive select 0: 19.44 MHz reference, divide by 8 or 8/3
// - receive select 1: 6.480 MHz reference, divide by 24 or 8
// - descrambling applied unless descramble-off bit is set
// - writing 1 to force bit declares out-of-frame at next frame boundary
// - parity error interrupt enable lets section parity errors pull interrupt low
// - signal loss interrupt enable lets loss of signal pull interrupt low
// - frame loss interrupt enable lets loss of frame pull interrupt low
// - out-of-frame interrupt enable lets out-of-frame pull interrupt low
// - parity flag bit 6 latches on parity error, clears on status read
// - signal, frame, out-of-frame flags latch on change, clear on status read
// - frame loss sets after 3 ms out of frame, clears after 3 ms in frame
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int LOF_CYCLES = `SCC_LOF_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tx_pll_bypass,
  input wire logic i_rx_cdr_bypass,
  input wire logic i_line_rate_select,
  input wire logic i_rx_cdr_active,
  input wire logic i_tx_freq_off,
  input wire logic i_rx_freq_off,
  input wire logic i_rx_no_trans_80,
  input wire logic i_parity_err,
  input wire logic i_signal_loss,
  input wire logic i_oof_detect,
  input wire logic i_frame_boundary,
  output logic o_line_loopback_en,
  output logic o_diag_loopback_en,
  output logic [1:0] o_tx_clk_src,
  output logic [1:0] o_tx_mult,
  output logic [1:0] o_rx_div,
  output logic o_tx_ref_sel_eff,
  output logic o_rx_ref_sel_eff,
  output logic o_rx_descramble_en,
  output logic o_force_oof,
  output logic o_irq_n
);
  // refuse a persistence count that the counter cannot serve
  if (LOF_CYCLES < 2) begin : g_bad_lof
    $error("LOF_CYCLES too small");
  end

  localparam int CW = $clog2(LOF_CYCLES + 1);

  // reset release through two flops
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // pin synchronisers: first stage feeds only second stage
  localparam int NS = 11;
  logic [NS-1:0] pin_meta_q, pin_q;
  wire logic [NS-1:0] pins = {i_tx_pll_bypass, i_rx_cdr_bypass, i_line_rate_select,
    i_rx_cdr_active, i_tx_freq_off, i_rx_freq_off, i_rx_no_trans_80, i_parity_err,
    i_signal_loss, i_oof_detect, i_frame_boundary};
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= '0;
      pin_q <= '0;
    end else begin
      pin_meta_q <= pins;
      pin_q <= pin_meta_q;
    end
  end
  wire logic tx_pll_bypass = pin_q[10];
  wire logic rx_cdr_bypass = pin_q[9];
  wire logic rate_hi = pin_q[8];
  wire logic cdr_act = pin_q[7];
  wire logic tx_off = pin_q[6];
  wire logic rx_off = pin_q[5];
  wire logic rx_notr = pin_q[4];
  wire logic bip_err = pin_q[3];
  wire logic los_in = pin_q[2];
  wire logic oof_in = pin_q[1];
  wire logic frm_bnd = pin_q[0];

  // register index of a byte address, or ff when misaligned/out of range
  function automatic logic [7:0] reg_idx(input logic [31:0] addr);
    if (addr[1:0] != 2'b00 || addr[31:10] != '0) reg_idx = 8'hff;
    else reg_idx = addr[9:2];
  endfunction

  wire logic [7:0] idx = reg_idx(i_paddr);
  wire logic acc = i_psel && i_penable && !o_pready;
  wire logic wr = acc && i_pwrite;
  wire logic rd = acc && !i_pwrite;
  wire logic stat_rd = rd && idx == `SCC_IDX_RX_SEC_STAT;

  // control registers
  logic lle_q, dle_q, loop_timing_en_q, tx_irq_en_q, tx_sel_q, rx_irq_en_q, rx_sel_q;
  logic dds_q, bip_en_q, los_en_q, lof_en_q, oof_en_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {lle_q, dle_q, loop_timing_en_q} <= 3'h0;
      {tx_irq_en_q, tx_sel_q, rx_irq_en_q, rx_sel_q} <= 4'h0;
      {dds_q, bip_en_q, los_en_q, lof_en_q, oof_en_q} <= 5'h00;
    end else if (wr) begin
      if (idx == `SCC_IDX_MASTER_CTRL) begin
        lle_q <= i_pwdata[`SCC_BIT_LINE_LB];
        dle_q <= i_pwdata[`SCC_BIT_DIAG_LB];
        loop_timing_en_q <= i_pwdata[`SCC_BIT_LOOP_TIMING];
      end else if (idx == `SCC_IDX_TX_SYNTH) begin
        tx_irq_en_q <= i_pwdata[`SCC_BIT_LOCK_IRQ_EN];
        tx_sel_q <= i_pwdata[`SCC_BIT_REF_SEL];
      end else if (idx == `SCC_IDX_RX_SYNTH) begin
        rx_irq_en_q <= i_pwdata[`SCC_BIT_LOCK_IRQ_EN];
        rx_sel_q <= i_pwdata[`SCC_BIT_REF_SEL];
      end else if (idx == `SCC_IDX_RX_SEC_CTRL) begin
        dds_q <= i_pwdata[`SCC_BIT_DESCR_OFF];
        bip_en_q <= i_pwdata[`SCC_BIT_PARITY_EN];
        los_en_q <= i_pwdata[`SCC_BIT_SIG_LOSS_EN];
        lof_en_q <= i_pwdata[`SCC_BIT_FRM_LOSS_EN];
        oof_en_q <= i_pwdata[`SCC_BIT_OOF_EN];
      end
    end
  end

  // force out-of-frame: armed by write of 1, fired at next frame boundary
  logic force_out_of_frame_arm_q, force_oof_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      force_out_of_frame_arm_q <= 1'b0;
      force_oof_q <= 1'b0;
    end else begin
      force_oof_q <= force_out_of_frame_arm_q && frm_bnd;
      if (wr && idx == `SCC_IDX_RX_SEC_CTRL && i_pwdata[`SCC_BIT_FORCE_OOF])
        force_out_of_frame_arm_q <= 1'b1;
      else if (frm_bnd) force_out_of_frame_arm_q <= 1'b0;
    end
  end

  // out-of-frame state: detector or forced
  logic oof_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) oof_q <= 1'b0;
    else if (force_oof_q) oof_q <= 1'b1;
    else oof_q <= oof_in;
  end

  // loss of frame with 3 ms persistence each way
  logic lof_q;
  logic [CW-1:0] lof_cnt_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lof_q <= 1'b0;
      lof_cnt_q <= '0;
    end else if (oof_q == lof_q) begin
      lof_cnt_q <= '0;
    end else if (lof_cnt_q == CW'(LOF_CYCLES - 1)) begin
      lof_q <= ~lof_q;
      lof_cnt_q <= '0;
    end else begin
      lof_cnt_q <= lof_cnt_q + CW'(1);
    end
  end
  // frame loss never moves before the full persistence count
  a_lof_early: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (lof_cnt_q != CW'(LOF_CYCLES - 1)) |=> $stable(lof_q))
    else $error("frame loss moved early");

  // lock-loss and signal-loss states
  logic tx_ool_q, rx_ool_q, los_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_ool_q <= 1'b0;
      rx_ool_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      tx_ool_q <= tx_off;
      rx_ool_q <= rx_off || rx_notr;
      los_q <= los_in;
    end
  end
  // lock-loss states follow their comparator inputs
  a_tx_ool_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    tx_off |=> tx_ool_q)
    else $error("tx lock loss missed");
  a_tx_ool_clr: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    !tx_off |=> !tx_ool_q)
    else $error("tx lock loss stuck");
  a_rx_ool_clr: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!rx_off && !rx_notr) |=> !rx_ool_q)
    else $error("rx lock loss stuck");

  // sticky event flags: set wins over read clear
  logic tx_fl_q, rx_fl_q, bip_fl_q, los_fl_q, lof_fl_q, oof_fl_q;
  logic tx_ool_d1_q, rx_ool_d1_q, los_d1_q, lof_d1_q, oof_d1_q;
  wire logic tx_chg = tx_ool_q ^ tx_ool_d1_q;
  wire logic rx_chg = rx_ool_q ^ rx_ool_d1_q;
  wire logic los_chg = los_q ^ los_d1_q;
  wire logic lof_chg = lof_q ^ lof_d1_q;
  wire logic oof_chg = oof_q ^ oof_d1_q;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {tx_ool_d1_q, rx_ool_d1_q, los_d1_q, lof_d1_q, oof_d1_q} <= 5'h00;
      {tx_fl_q, rx_fl_q} <= 2'h0;
      {bip_fl_q, los_fl_q, lof_fl_q, oof_fl_q} <= 4'h0;
    end else begin
      {tx_ool_d1_q, rx_ool_d1_q, los_d1_q, lof_d1_q, oof_d1_q} <=
        {tx_ool_q, rx_ool_q, los_q, lof_q, oof_q};
      tx_fl_q <= tx_chg || (tx_fl_q && !(rd && idx == `SCC_IDX_TX_SYNTH));
      rx_fl_q <= rx_chg || (rx_fl_q && !(rd && idx == `SCC_IDX_RX_SYNTH));
      bip_fl_q <= bip_err || (bip_fl_q && !stat_rd);
      los_fl_q <= los_chg || (los_fl_q && !stat_rd);
      lof_fl_q <= lof_chg || (lof_fl_q && !stat_rd);
      oof_fl_q <= oof_chg || (oof_fl_q && !stat_rd);
    end
  end
  // every state change leaves its flag set
  a_tx_chg_flag: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    tx_chg |=> tx_fl_q)
    else $error("tx lock change flag missed");
  a_rx_chg_flag: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    rx_chg |=> rx_fl_q)
    else $error("rx lock change flag missed");
  a_oof_change: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    $changed(oof_q) |=> oof_fl_q)
    else $error("out-of-frame flag missed");

  // interrupt pin, low while any enabled flag is set
  wire logic irq_any = (tx_fl_q && tx_irq_en_q) || (rx_fl_q && rx_irq_en_q)
    || (bip_fl_q && bip_en_q) || (los_fl_q && los_en_q)
    || (lof_fl_q && lof_en_q) || (oof_fl_q && oof_en_q);
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) o_irq_n <= 1'b1;
    else o_irq_n <= !irq_any;
  end
  // with every enable off the pin stays released
  a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!tx_irq_en_q && !rx_irq_en_q && !bip_en_q && !los_en_q && !lof_en_q && !oof_en_q) |=> o_irq_n)
    else $error("irq low with all enables off");

  // clock source and synthesizer setting
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_tx_clk_src <= SCC_CLK_REF_TX;
      o_tx_mult <= SCC_MUL_X8;
      o_rx_div <= SCC_MUL_X8;
      o_tx_ref_sel_eff <= 1'b0;
      o_rx_ref_sel_eff <= 1'b0;
    end else begin
      if (!loop_timing_en_q) o_tx_clk_src <= SCC_CLK_REF_TX;
      else if (cdr_act) o_tx_clk_src <= SCC_CLK_RECOVERED;
      else o_tx_clk_src <= SCC_CLK_REF_RX;
      o_tx_ref_sel_eff <= tx_pll_bypass ? 1'b0 : tx_sel_q;
      o_rx_ref_sel_eff <= rx_cdr_bypass ? 1'b0 : rx_sel_q;
      if (tx_pll_bypass) o_tx_mult <= SCC_MUL_BYPASS;
      else if (!tx_sel_q) o_tx_mult <= rate_hi ? SCC_MUL_X8 : SCC_MUL_X8_3RD;
      else o_tx_mult <= rate_hi ? SCC_MUL_X24 : SCC_MUL_X8;
      if (rx_cdr_bypass) o_rx_div <= SCC_MUL_BYPASS;
      else if (!rx_sel_q) o_rx_div <= rate_hi ? SCC_MUL_X8 : SCC_MUL_X8_3RD;
      else o_rx_div <= rate_hi ? SCC_MUL_X24 : SCC_MUL_X8;
    end
  end
  // bypass, loop timing and rate settings reach the clock outputs
  a_tx_bypass: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    tx_pll_bypass |=> (o_tx_mult == SCC_MUL_BYPASS && !o_tx_ref_sel_eff))
    else $error("tx bypass not honoured");
  a_rx_bypass: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    rx_cdr_bypass |=> (o_rx_div == SCC_MUL_BYPASS && !o_rx_ref_sel_eff))
    else $error("rx bypass not honoured");
  a_loop_recovered: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (loop_timing_en_q && cdr_act) |=> o_tx_clk_src == SCC_CLK_RECOVERED)
    else $error("loop timing source wrong");
  a_tx_low_rate: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!tx_pll_bypass && !tx_sel_q && !rate_hi) |=> o_tx_mult == SCC_MUL_X8_3RD)
    else $error("tx low rate multiplier wrong");
  a_tx_sel_high: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!tx_pll_bypass && tx_sel_q && rate_hi) |=> o_tx_mult == SCC_MUL_X24)
    else $error("tx high rate multiplier wrong");
  a_rx_low_rate: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!rx_cdr_bypass && !rx_sel_q && !rate_hi) |=> o_rx_div == SCC_MUL_X8_3RD)
    else $error("rx low rate divisor wrong");
  a_rx_sel_high: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (!rx_cdr_bypass && rx_sel_q && rate_hi) |=> o_rx_div == SCC_MUL_X24)
    else $error("rx high rate divisor wrong");

  // datapath controls
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_line_loopback_en <= 1'b0;
      o_diag_loopback_en <= 1'b0;
      o_rx_descramble_en <= 1'b1;
      o_force_oof <= 1'b0;
    end else begin
      o_line_loopback_en <= lle_q;
      o_diag_loopback_en <= dle_q;
      o_rx_descramble_en <= !dds_q;
      o_force_oof <= force_oof_q;
    end
  end
  // control bits reach the datapath one cycle later
  a_line_loop: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    lle_q |=> o_line_loopback_en)
    else $error("line loopback not applied");
  a_diag_loop: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    dle_q |=> o_diag_loopback_en)
    else $error("diagnostic loopback not applied");
  a_descr_off: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    dds_q |=> !o_rx_descramble_en)
    else $error("descrambling not turned off");
  a_descr_on: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    !dds_q |=> o_rx_descramble_en)
    else $error("descrambling not applied");

  // apb answer: one wait state, read data muxed by index
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    if (idx == `SCC_IDX_MASTER_CTRL) rdata = {5'h00, lle_q, dle_q, loop_timing_en_q};
    else if (idx == `SCC_IDX_TX_SYNTH) rdata = {4'h0, tx_ool_q, 1'b0, tx_irq_en_q, tx_sel_q};
    else if (idx == `SCC_IDX_RX_SYNTH) rdata = {4'h0, rx_ool_q, 1'b0, rx_irq_en_q, rx_sel_q};
    else if (idx == `SCC_IDX_RX_SEC_CTRL)
      rdata = {1'b0, dds_q, 2'b00, bip_en_q, los_en_q, lof_en_q, oof_en_q};
    else if (idx == `SCC_IDX_RX_SEC_STAT)
      rdata = {1'b0, bip_fl_q, los_fl_q, lof_fl_q, oof_fl_q, los_q, lof_q, oof_q};
  end
  wire logic mapped = idx == `SCC_IDX_MASTER_CTRL || idx == `SCC_IDX_TX_SYNTH ||
    idx == `SCC_IDX_RX_SYNTH || idx == `SCC_IDX_RX_SEC_CTRL || idx == `SCC_IDX_RX_SEC_STAT;
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc && !mapped;
      o_prdata <= rd ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  // checks
  a_irq_follows_flag: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (bip_fl_q && bip_en_q) |=> !o_irq_n) else $error("irq not low for parity flag");
  a_bip_latch: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    bip_err |=> bip_fl_q) else $error("parity flag not latched");
  a_stat_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (stat_rd && !bip_err) |=> !bip_fl_q) else $error("parity flag not cleared");
  a_los_change: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    $changed(los_q) |=> los_fl_q) else $error("signal flag missed");
  a_lof_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    $rose(lof_q) |-> $past(oof_q)) else $error("frame loss without oof");
  a_tx_src: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    !loop_timing_en_q |=> o_tx_clk_src == SCC_CLK_REF_TX) else $error("tx source wrong");
  a_rx_ool: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    rx_notr |=> rx_ool_q) else $error("rx lock loss missed");
  a_force_out_of_frame_fire: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    (force_out_of_frame_arm_q && frm_bnd) |=> ##1 oof_q) else $error("forced oof missing");
  a_irq_quiet: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q)
    !irq_any |=> o_irq_n) else $error("irq low with no flag");
endmodule // scc_ctrl

// ---- scc_cfg.svh ----
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
// register indices; byte address is four times the index
`define SCC_IDX_MASTER_CTRL 8'h05
`define SCC_IDX_TX_SYNTH 8'h06
`define SCC_IDX_RX_SYNTH 8'h07
`define SCC_IDX_RX_SEC_CTRL 8'h10
`define SCC_IDX_RX_SEC_STAT 8'h11
// master control fields
`define SCC_BIT_LINE_LB 2
`define SCC_BIT_DIAG_LB 1
`define SCC_BIT_LOOP_TIMING 0
// synth control fields
`define SCC_BIT_LOCK_STATE 3
`define SCC_BIT_LOCK_IRQ_EN 1
`define SCC_BIT_REF_SEL 0
// section control fields
`define SCC_BIT_DESCR_OFF 6
`define SCC_BIT_FORCE_OOF 5
`define SCC_BIT_PARITY_EN 3
`define SCC_BIT_SIG_LOSS_EN 2
`define SCC_BIT_FRM_LOSS_EN 1
`define SCC_BIT_OOF_EN 0
// section status fields
`define SCC_BIT_PARITY_FLAG 6
`define SCC_BIT_SIG_LOSS_FLAG 5
`define SCC_BIT_FRM_LOSS_FLAG 4
`define SCC_BIT_OOF_FLAG 3
`define SCC_BIT_SIG_LOSS_ST 2
`define SCC_BIT_FRM_LOSS_ST 1
`define SCC_BIT_OOF_ST 0
// timing
`define SCC_CLK_HZ 50000000
`define SCC_LOF_TIME_US 3000
`define SCC_LOF_CYCLES ((`SCC_LOF_TIME_US * (`SCC_CLK_HZ / 1000000)) + 1)
`endif

// ---- scc_pkg.sv ----
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_CLK_REF_TX,
    SCC_CLK_REF_RX,
    SCC_CLK_RECOVERED
  } scc_tx_clk_src_t;
  typedef enum logic [1:0] {
    SCC_MUL_X8,
    SCC_MUL_X8_3RD,
    SCC_MUL_X24,
    SCC_MUL_BYPASS
  } scc_mult_t;
endpackage

// ---- scc_line_model.sv ----
`timescale 1ns/1ps
// far-side model: line status levels and a free-running frame pulse
module scc_line_model #(
  parameter int FRAME_CYCLES = 16
) (
  input wire logic i_sys_clk,
  output logic o_parity_err,
  output logic o_signal_loss,
  output logic o_oof_detect,
  output logic o_frame_boundary,
  output logic o_tx_freq_off,
  output logic o_rx_freq_off,
  output logic o_rx_no_trans_80
);
  int fcnt = 0;
  initial begin
    o_parity_err = 1'b0;
    o_frame_boundary = 1'b0;
    {o_signal_loss, o_oof_detect, o_tx_freq_off, o_rx_freq_off, o_rx_no_trans_80} = 5'h00;
  end
  // one-cycle frame pulse every frame period
  always @(posedge i_sys_clk) begin
    fcnt <= (fcnt == FRAME_CYCLES - 1) ? 0 : fcnt + 1;
    o_frame_boundary <= (fcnt == 0);
  end
  // status levels change just after an edge
  task automatic set_lines(input logic [4:0] v);
    @(posedge i_sys_clk);
    {o_signal_loss, o_oof_detect, o_tx_freq_off, o_rx_freq_off, o_rx_no_trans_80} <= v;
  endtask
  // single errored frame parity
  task automatic pulse_parity;
    @(posedge i_sys_clk);
    o_parity_err <= 1'b1;
    @(posedge i_sys_clk);
    o_parity_err <= 1'b0;
  endtask
endmodule // scc_line_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "scc_cfg.svh"
module tb_top;
  import scc_pkg::*;
  localparam int LOF = 20;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, errv;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic tx_byp, rx_byp, rate, cdr_act, sel, byp;
  logic tx_off, rx_off, no_tr, par, los, oof, fb, line_lb, diag_lb, tx_sel, rx_sel;
  logic descr_en, force_oof, irq_n;
  logic [1:0] tx_src, tx_mult, rx_div, m;
  int n_mismatch = 0, samples_checked = 0, hits;
  // 50 MHz clock
  always #10 i_sys_clk = ~i_sys_clk;
  scc_ctrl #(.LOF_CYCLES(LOF)) i_dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_tx_pll_bypass(tx_byp),
    .i_rx_cdr_bypass(rx_byp), .i_line_rate_select(rate), .i_rx_cdr_active(cdr_act),
    .i_tx_freq_off(tx_off), .i_rx_freq_off(rx_off), .i_rx_no_trans_80(no_tr),
    .i_parity_err(par), .i_signal_loss(los), .i_oof_detect(oof), .i_frame_boundary(fb),
    .o_line_loopback_en(line_lb), .o_diag_loopback_en(diag_lb), .o_tx_clk_src(tx_src),
    .o_tx_mult(tx_mult), .o_rx_div(rx_div), .o_tx_ref_sel_eff(tx_sel),
    .o_rx_ref_sel_eff(rx_sel), .o_rx_descramble_en(descr_en), .o_force_oof(force_oof),
    .o_irq_n(irq_n));
  scc_line_model i_line (
    .i_sys_clk(i_sys_clk), .o_parity_err(par), .o_signal_loss(los), .o_oof_detect(oof),
    .o_frame_boundary(fb), .o_tx_freq_off(tx_off), .o_rx_freq_off(rx_off),
    .o_rx_no_trans_80(no_tr));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chkb(input string nm, input logic seen, input logic exp);
    chk(nm, 32'(seen), 32'(exp));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one transfer; byte address is four times the register index
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge i_sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, rdv, {24'h0, exp});
  endtask
  // input sync plus flag and pin stages
  task automatic settle;
    repeat (6) @(posedge i_sys_clk);
  endtask
  // guard against a hang
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, tx_byp, rx_byp, cdr_act} <= 6'h00;
    rate <= 1'b1;
    paddr <= 32'h0;
    pwdata <= 32'h0;
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chkb("irq_n", irq_n, 1'b1);
    chkb("descramble", descr_en, 1'b1);
    rdc(`SCC_IDX_TX_SYNTH, 8'h00, "tx synth");
    rdc(`SCC_IDX_RX_SYNTH, 8'h00, "rx synth");
    rdc(`SCC_IDX_RX_SEC_CTRL, 8'h00, "sec ctrl");
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h00, "sec stat");
    apb(1'b0, 8'h08, 8'h00);
    chkb("unmapped err", errv, 1'b1);
    chk("unmapped data", rdv, 32'h0);
    // loopbacks one at a time, then loop timing sources
    wrr(`SCC_IDX_MASTER_CTRL, 8'h04);
    settle();
    chkb("line loop", line_lb, 1'b1);
    chkb("diag loop", diag_lb, 1'b0);
    wrr(`SCC_IDX_MASTER_CTRL, 8'h02);
    settle();
    chkb("diag loop", diag_lb, 1'b1);
    chkb("line loop", line_lb, 1'b0);
    wrr(`SCC_IDX_MASTER_CTRL, 8'h01);
    settle();
    chk("tx src", 32'(tx_src), 32'(SCC_CLK_REF_RX));
    rdc(`SCC_IDX_MASTER_CTRL, 8'h01, "master ctrl");
    cdr_act <= 1'b1;
    settle();
    chk("tx src", 32'(tx_src), 32'(SCC_CLK_RECOVERED));
    wrr(`SCC_IDX_MASTER_CTRL, 8'h00);
    settle();
    chk("tx src", 32'(tx_src), 32'(SCC_CLK_REF_TX));
    // every select, rate and bypass combination
    for (int k = 0; k < 8; k++) begin
      sel = k[0];
      byp = k[2];
      wrr(`SCC_IDX_TX_SYNTH, {7'h0, sel});
      wrr(`SCC_IDX_RX_SYNTH, {7'h0, sel});
      rate <= k[1];
      tx_byp <= byp;
      rx_byp <= byp;
      settle();
      m = byp ? SCC_MUL_BYPASS : sel ? (k[1] ? SCC_MUL_X24 : SCC_MUL_X8)
          : (k[1] ? SCC_MUL_X8 : SCC_MUL_X8_3RD);
      chk("tx mult", 32'(tx_mult), 32'(m));
      chk("rx div", 32'(rx_div), 32'(m));
      chkb("tx sel", tx_sel, sel & ~byp);
      chkb("rx sel", rx_sel, sel & ~byp);
    end
    tx_byp <= 1'b0;
    rx_byp <= 1'b0;
    // lock-loss state changes, enabled then masked
    wrr(`SCC_IDX_TX_SYNTH, 8'h02);
    wrr(`SCC_IDX_RX_SYNTH, 8'h02);
    i_line.set_lines(5'b00100);
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_TX_SYNTH, 8'h0a, "tx synth");
    settle();
    chkb("irq_n", irq_n, 1'b1);
    i_line.set_lines(5'b00000);
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_TX_SYNTH, 8'h02, "tx synth");
    i_line.set_lines(5'b00001);
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_RX_SYNTH, 8'h0a, "rx synth");
    wrr(`SCC_IDX_RX_SYNTH, 8'h00);
    wrr(`SCC_IDX_TX_SYNTH, 8'h00);
    i_line.set_lines(5'b00100);
    settle();
    chkb("irq_n", irq_n, 1'b1);
    rdc(`SCC_IDX_RX_SYNTH, 8'h00, "rx synth");
    i_line.set_lines(5'b00110);
    settle();
    chkb("irq_n", irq_n, 1'b1);
    rdc(`SCC_IDX_RX_SYNTH, 8'h08, "rx synth");
    rdc(`SCC_IDX_TX_SYNTH, 8'h08, "tx synth");
    i_line.set_lines(5'b00000);
    // parity error, enabled then masked
    wrr(`SCC_IDX_RX_SEC_CTRL, 8'h08);
    i_line.pulse_parity();
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h40, "sec stat");
    settle();
    chkb("irq_n", irq_n, 1'b1);
    wrr(`SCC_IDX_RX_SEC_CTRL, 8'h00);
    i_line.pulse_parity();
    settle();
    chkb("irq_n", irq_n, 1'b1);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h40, "sec stat");
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h00, "sec stat");
    // signal loss
    wrr(`SCC_IDX_RX_SEC_CTRL, 8'h04);
    i_line.set_lines(5'b10000);
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h24, "sec stat");
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h04, "sec stat");
    i_line.set_lines(5'b00000);
    settle();
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h20, "sec stat");
    // out of frame, then frame loss after the persistence time
    wrr(`SCC_IDX_RX_SEC_CTRL, 8'h03);
    i_line.set_lines(5'b01000);
    settle();
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h09, "sec stat");
    repeat (LOF + 10) @(posedge i_sys_clk);
    chkb("irq_n", irq_n, 1'b0);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h13, "sec stat");
    i_line.set_lines(5'b00000);
    settle();
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h0a, "sec stat");
    repeat (LOF + 10) @(posedge i_sys_clk);
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h10, "sec stat");
    settle();
    chkb("irq_n", irq_n, 1'b1);
    // descramble off and a forced out-of-frame in one write
    wrr(`SCC_IDX_RX_SEC_CTRL, 8'h60);
    hits = 0;
    repeat (40) begin
      @(posedge i_sys_clk);
      if (force_oof === 1'b1) hits++;
    end
    chk("force oof", 32'(hits), 32'h1);
    chkb("descramble", descr_en, 1'b0);
    rdc(`SCC_IDX_RX_SEC_CTRL, 8'h40, "sec ctrl");
    rdc(`SCC_IDX_RX_SEC_STAT, 8'h08, "sec stat");
    wrap_up();
  end
endmodule // tb_top
